// *** inc/mcd_defs.svh ***
`ifndef MCD_DEFS_SVH
`define MCD_DEFS_SVH

// ==========================================================
// Register offsets
`define MCD_OFF_CS_CTRL    8'h44
`define MCD_OFF_HOLE_BOT   8'h45
`define MCD_OFF_HOLE_TOP   8'h46
`define MCD_OFF_TOP_MEM    8'h47
`define MCD_OFF_FWD_CTRL   8'h48
`define MCD_OFF_STATUS     8'h4f

// ==========================================================
// Reset values
`define MCD_RST_CS_CTRL    5'h00
`define MCD_RST_HOLE_BOT   8'h10
`define MCD_RST_HOLE_TOP   8'h0f
`define MCD_RST_TOP_MEM    8'h00
`define MCD_RST_FWD_CTRL   8'h01

// ==========================================================
// Field positions
`define MCD_CS_MASTER_EN   4
`define MCD_CS_MID_RE      0
`define MCD_CS_MID_WE      1
`define MCD_CS_BIOS_RE     2
`define MCD_CS_BIOS_WE     3
`define MCD_FWD_TOP_MSB    7
`define MCD_FWD_TOP_LSB    4
`define MCD_HOLE_ADDR_MSB  23
`define MCD_HOLE_ADDR_LSB  16
`define MCD_TOM_ADDR_MSB   28
`define MCD_TOM_ADDR_LSB   21
`define MCD_MB_ADDR_MSB    23
`define MCD_MB_ADDR_LSB    20

// ==========================================================
// Low block hit vector positions
`define MCD_BLK_BASE       0
`define MCD_BLK_MID        1
`define MCD_BLK_VGA        2
`define MCD_BLK_LBIOS      3
`define MCD_BLK_UBIOS      4

// Decode latency in clock cycles
`define MCD_DECODE_LAT     1

`endif

// *** inc/mcd_pkg.sv ***
package mcd_pkg;

    // ======================================================
    // Bus and request carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mcd_reg_req_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
    } mcd_pci_req_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
    } mcd_isa_req_t;

    // ======================================================
    // Module state
    typedef struct packed {
        logic       cs_n;
        logic       cs_valid;
        logic       fwd;
        logic       fwd_valid;
    } mcd_result_t;

    typedef struct packed {
        logic [4:0]  chip_select_control;
        logic [7:0]  chip_select_hole_bottom;
        logic [7:0]  chip_select_hole_top;
        logic [7:0]  chip_select_top_of_memory;
        logic [7:0]  isa_forwarding_control;
        logic [7:0]  rdata;
        mcd_result_t res;
        logic        wr_seen;
    } mcd_state_t;

endpackage

// *** rtl/mcd_decoder.sv ***
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "mcd_defs.svh"
// How it works
// [RULE1] Hole bottom register bits map to address bits 23:16, 64K units.
// [RULE2] Hole top register bits map to address bits 23:16, 64K units.
// [RULE3] No chip select inside the hole, both limits inclusive.
// [RULE4] Hole top below hole bottom disables the hole.
// [RULE5] Hole matches only when address bits 31:24 are zero.
// [RULE6] Software keeps hole bottom at or above 1M and top above 1M.
// [RULE7] Reset loads hole bottom 10h and hole top 0Fh, hole off.
// [RULE8] Top-of-memory bits map to address bits 28:21, 2M steps.
// [RULE9] Chip select from 2M up to top of memory, except the hole.
// [RULE10] Value N ends region at (N+1)*2M-1; zero leaves it empty.
// [RULE11] Forwarding field bits 7:4 set ISA-to-PCI top in 1M steps.
// [RULE12] ISA/DMA cycles from 1M to forwarding top go to PCI, except hole.
// [RULE13] Forwarding control resets to 01h, decode registers to defaults.
// [RULE14] Master enable low means chip select never asserted.
// [RULE15] Forwarding bits 3:0 enable fixed low blocks to PCI.
// [RULE16] Address phase compared combinationally, result one clock later.
module mcd_decoder
    import mcd_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         reset_n_in,
    // Register port
    input  wire mcd_reg_req_t reg_req_in,
    output logic [7:0]        reg_rdata_out,
    // PCI address phase
    input  wire mcd_pci_req_t pci_req_in,
    output logic              main_memory_chip_select_n_out,
    output logic              chip_select_valid_out,
    // ISA master / DMA memory cycle
    input  wire mcd_isa_req_t isa_req_in,
    output logic              isa_forward_out,
    output logic              isa_forward_valid_out
);

    // ======================================================
    // State
    mcd_state_t st;
    mcd_state_t next_st;

    logic [4:0] pci_low_hit;
    logic [4:0] isa_low_hit;
    logic       pci_hole_rng;
    logic       isa_hole_rng;
    logic       pci_tom_rng;
    logic       isa_fwd_rng;
    logic       pci_below_16m;
    logic       pci_in_hole;
    logic       isa_in_hole;
    logic       pci_low_cs;
    logic       pci_high_cs;
    logic       pci_cs_hit;
    logic       isa_low_fwd;
    logic       isa_fwd_hit;
    logic       hole_active;
    logic       master_en;

    // ======================================================
    // Address compares
    mcd_range_cmp #(.WIDTH(8)) u_pci_hole (
        .lo_in   (st.chip_select_hole_bottom),
        .hi_in   (st.chip_select_hole_top),
        .x_in    (pci_req_in.addr[`MCD_HOLE_ADDR_MSB:`MCD_HOLE_ADDR_LSB]), // RULE1 RULE2
        .hit_out (pci_hole_rng)
    );

    mcd_range_cmp #(.WIDTH(8)) u_isa_hole (
        .lo_in   (st.chip_select_hole_bottom),
        .hi_in   (st.chip_select_hole_top),
        .x_in    (isa_req_in.addr[`MCD_HOLE_ADDR_MSB:`MCD_HOLE_ADDR_LSB]),
        .hit_out (isa_hole_rng)
    );

    // Lower bound 1 is the 2M floor; upper bound N ends at (N+1)*2M-1
    mcd_range_cmp #(.WIDTH(8)) u_pci_tom (
        .lo_in   (8'h01),
        .hi_in   (st.chip_select_top_of_memory),
        .x_in    (pci_req_in.addr[`MCD_TOM_ADDR_MSB:`MCD_TOM_ADDR_LSB]), // RULE8 RULE10
        .hit_out (pci_tom_rng)
    );

    // Code c ends the forwarding region at (c+1)M-1
    mcd_range_cmp #(.WIDTH(4)) u_isa_fwd (
        .lo_in   (4'h1),
        .hi_in   (st.isa_forwarding_control[`MCD_FWD_TOP_MSB:`MCD_FWD_TOP_LSB]), // RULE11
        .x_in    (isa_req_in.addr[`MCD_MB_ADDR_MSB:`MCD_MB_ADDR_LSB]),
        .hit_out (isa_fwd_rng)
    );

    mcd_low_dec u_pci_low (
        .addr_in (pci_req_in.addr[23:0]),
        .hit_out (pci_low_hit)
    );

    mcd_low_dec u_isa_low (
        .addr_in (isa_req_in.addr),
        .hit_out (isa_low_hit)
    );

    // ======================================================
    // Decode terms
    always_comb begin
        master_en     = st.chip_select_control[`MCD_CS_MASTER_EN];
        pci_below_16m = (pci_req_in.addr[31:24] == 8'h00);
        // The range compare is empty when top < bottom
        hole_active   = (st.chip_select_hole_top >= st.chip_select_hole_bottom); // RULE4
        pci_in_hole   = pci_below_16m && pci_hole_rng; // RULE5
        isa_in_hole   = isa_hole_rng;
        pci_low_cs    = pci_below_16m && (pci_low_hit[`MCD_BLK_BASE]
                      || (pci_low_hit[`MCD_BLK_MID] && (pci_req_in.write
                          ? st.chip_select_control[`MCD_CS_MID_WE]
                          : st.chip_select_control[`MCD_CS_MID_RE]))
                      || (pci_low_hit[`MCD_BLK_UBIOS] && (pci_req_in.write
                          ? st.chip_select_control[`MCD_CS_BIOS_WE]
                          : st.chip_select_control[`MCD_CS_BIOS_RE])));
        pci_high_cs   = (pci_req_in.addr[31:29] == 3'h0) && pci_tom_rng; // RULE9
        pci_cs_hit    = master_en && (pci_low_cs || pci_high_cs) && !pci_in_hole; // RULE3 RULE14
        isa_low_fwd   = |(st.isa_forwarding_control[3:0] & isa_low_hit[3:0]); // RULE15
        isa_fwd_hit   = (isa_low_fwd || isa_fwd_rng) && !isa_in_hole; // RULE12
    end

    // ======================================================
    // Next state
    always_comb begin
        next_st = st;
        // Read data stands for one cycle only
        next_st.rdata = 8'h00;
        if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                `MCD_OFF_CS_CTRL: begin
                    next_st.chip_select_control = reg_req_in.wdata[4:0];
                    next_st.wr_seen = 1'b1;
                end
                `MCD_OFF_HOLE_BOT: begin
                    next_st.chip_select_hole_bottom = reg_req_in.wdata;
                    next_st.wr_seen = 1'b1;
                end
                `MCD_OFF_HOLE_TOP: begin
                    next_st.chip_select_hole_top = reg_req_in.wdata;
                    next_st.wr_seen = 1'b1;
                end
                `MCD_OFF_TOP_MEM: begin
                    next_st.chip_select_top_of_memory = reg_req_in.wdata;
                    next_st.wr_seen = 1'b1;
                end
                `MCD_OFF_FWD_CTRL: begin
                    next_st.isa_forwarding_control = reg_req_in.wdata;
                    next_st.wr_seen = 1'b1;
                end
                default: begin
                    next_st.wr_seen = st.wr_seen;
                end
            endcase
        end
        if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                `MCD_OFF_CS_CTRL:  next_st.rdata = {3'h0, st.chip_select_control};
                `MCD_OFF_HOLE_BOT: next_st.rdata = st.chip_select_hole_bottom;
                `MCD_OFF_HOLE_TOP: next_st.rdata = st.chip_select_hole_top;
                `MCD_OFF_TOP_MEM:  next_st.rdata = st.chip_select_top_of_memory;
                `MCD_OFF_FWD_CTRL: next_st.rdata = st.isa_forwarding_control;
                `MCD_OFF_STATUS:   next_st.rdata = {5'h00, hole_active,
                                                   st.res.fwd, !st.res.cs_n};
                default:           next_st.rdata = 8'h00;
            endcase
        end
        // Outputs are one-cycle results of the address phase
        next_st.res.cs_valid  = pci_req_in.valid; // RULE16
        next_st.res.cs_n      = !(pci_req_in.valid && pci_cs_hit);
        next_st.res.fwd_valid = isa_req_in.valid;
        next_st.res.fwd       = isa_req_in.valid && isa_fwd_hit;
    end

    // ======================================================
    // Registers
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st.chip_select_control       <= `MCD_RST_CS_CTRL;
            st.chip_select_hole_bottom   <= `MCD_RST_HOLE_BOT; // RULE7
            st.chip_select_hole_top      <= `MCD_RST_HOLE_TOP; // RULE7
            st.chip_select_top_of_memory <= `MCD_RST_TOP_MEM; // RULE13
            st.isa_forwarding_control    <= `MCD_RST_FWD_CTRL; // RULE13
            st.rdata                     <= 8'h00;
            st.res.cs_n                  <= 1'b1;
            st.res.cs_valid              <= 1'b0;
            st.res.fwd                   <= 1'b0;
            st.res.fwd_valid             <= 1'b0;
            st.wr_seen                   <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_out                 = st.rdata;
    assign main_memory_chip_select_n_out = st.res.cs_n;
    assign chip_select_valid_out         = st.res.cs_valid;
    assign isa_forward_out               = st.res.fwd;
    assign isa_forward_valid_out         = st.res.fwd_valid;

    // ======================================================
    // Assertions
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    logic [7:0] a_tom_idx;
    logic [7:0] a_hole_idx;
    logic [3:0] a_mb_idx;
    logic       a_pci_hole;
    logic       a_isa_hole;
    assign a_tom_idx  = pci_req_in.addr[28:21];
    assign a_hole_idx = pci_req_in.addr[23:16];
    assign a_mb_idx   = isa_req_in.addr[23:20];
    assign a_pci_hole = pci_req_in.addr[31:24] == 8'h00
                     && a_hole_idx >= st.chip_select_hole_bottom
                     && a_hole_idx <= st.chip_select_hole_top;
    assign a_isa_hole = isa_req_in.addr[23:16] >= st.chip_select_hole_bottom
                     && isa_req_in.addr[23:16] <= st.chip_select_hole_top;

    hole_excludes_a: assert property ( // RULE3
        pci_req_in.valid && a_pci_hole |=> main_memory_chip_select_n_out && chip_select_valid_out)
        else $error("chip select asserted inside hole");

    hole_limits_a: assert property ( // RULE1
        pci_req_in.valid && master_en && pci_req_in.addr[31:24] == 8'h00
        && a_hole_idx == st.chip_select_hole_top && a_hole_idx == st.chip_select_hole_bottom
        |=> main_memory_chip_select_n_out)
        else $error("hole limit not inclusive");

    hole_off_a: assert property ( // RULE4
        pci_req_in.valid && master_en && st.chip_select_hole_top < st.chip_select_hole_bottom
        && pci_req_in.addr[31:29] == 3'h0 && a_tom_idx != 8'h00
        && a_tom_idx <= st.chip_select_top_of_memory |=> !main_memory_chip_select_n_out)
        else $error("disabled hole still excludes");

    hole_below16m_a: assert property ( // RULE5
        pci_req_in.valid && master_en && pci_req_in.addr[31:24] != 8'h00
        && pci_req_in.addr[31:29] == 3'h0 && a_tom_idx <= st.chip_select_top_of_memory
        |=> !main_memory_chip_select_n_out)
        else $error("hole matched above 16M");

    tom_region_a: assert property ( // RULE9
        pci_req_in.valid && master_en && !a_pci_hole && pci_req_in.addr[31:29] == 3'h0
        && a_tom_idx >= 8'h01 && a_tom_idx <= st.chip_select_top_of_memory
        |=> !main_memory_chip_select_n_out)
        else $error("chip select missing in region");

    tom_bound_a: assert property ( // RULE10
        pci_req_in.valid && pci_req_in.addr[31:24] != 8'h00
        && pci_req_in.addr[31:21] > {3'h0, st.chip_select_top_of_memory}
        |=> main_memory_chip_select_n_out)
        else $error("chip select above top of memory");

    master_off_a: assert property ( // RULE14
        pci_req_in.valid && !master_en |=> main_memory_chip_select_n_out)
        else $error("chip select with master disabled");

    decode_time_a: assert property ( // RULE16
        !pci_req_in.valid |=> main_memory_chip_select_n_out && !chip_select_valid_out)
        else $error("chip select outside decode slot");

    fwd_region_a: assert property ( // RULE11
        isa_req_in.valid && !a_isa_hole && a_mb_idx >= 4'h1
        && a_mb_idx <= st.isa_forwarding_control[7:4] |=> isa_forward_out)
        else $error("forward missing in region");

    fwd_hole_a: assert property ( // RULE12
        isa_req_in.valid && a_isa_hole |=> !isa_forward_out ##0 isa_forward_valid_out)
        else $error("forwarded inside hole");

    low_block_a: assert property ( // RULE15
        isa_req_in.valid && !a_isa_hole && isa_req_in.addr[23:19] == 5'h00
        |=> isa_forward_out == $past(st.isa_forwarding_control[0]))
        else $error("low block forward wrong");

    reset_vals_a: assert property ( // RULE13
        !st.wr_seen |-> st.chip_select_hole_bottom == 8'h10 && st.chip_select_hole_top == 8'h0f
        && st.chip_select_top_of_memory == 8'h00 && st.isa_forwarding_control == 8'h01)
        else $error("register left reset value unwritten");

    reset_hole_a: assert property ( // RULE7
        !st.wr_seen && pci_req_in.valid && pci_req_in.addr[31:20] == 12'h001
        |=> main_memory_chip_select_n_out)
        else $error("reset hole not disabled");

    read_back_a: assert property (
        reg_req_in.rd && reg_req_in.addr == `MCD_OFF_HOLE_TOP
        |=> reg_rdata_out == $past(st.chip_select_hole_top))
        else $error("read data mismatch");

    // Status shows the hole state of the read cycle, not of the data cycle
    status_hole_a: assert property ( // RULE4
        reg_req_in.rd && reg_req_in.addr == `MCD_OFF_STATUS
        |=> reg_rdata_out[2] == $past(st.chip_select_hole_top >= st.chip_select_hole_bottom))
        else $error("status hole bit wrong");

    // ======================================================
    // Covers
    hole_hit_c: cover property (pci_req_in.valid && master_en && hole_active && a_pci_hole);
    cs_hit_c:   cover property (pci_req_in.valid ##1 !main_memory_chip_select_n_out);
    fwd_hit_c:  cover property (isa_req_in.valid ##1 isa_forward_out);
    read_c:     cover property (reg_req_in.wr ##1 reg_req_in.rd);
    low_seg_c:  cover property (pci_req_in.valid && pci_low_hit[`MCD_BLK_MID]
                                ##1 !main_memory_chip_select_n_out);

endmodule

// *** rtl/mcd_low_dec.sv ***
`timescale 1ns/10ps
`include "mcd_defs.svh"
// ==========================================================
// Fixed low-memory block decode below 1 Mbyte
module mcd_low_dec (
    // Address
    input  wire logic [23:0] addr_in,
    // Block hits
    output logic [4:0]       hit_out
);
    // 0-512K
    assign hit_out[`MCD_BLK_BASE]  = (addr_in[23:19] == 5'h00);
    // 512-640K
    assign hit_out[`MCD_BLK_MID]   = (addr_in[23:17] == 7'h04);
    // 640-768K
    assign hit_out[`MCD_BLK_VGA]   = (addr_in[23:17] == 7'h05);
    // 896-960K
    assign hit_out[`MCD_BLK_LBIOS] = (addr_in[23:16] == 8'h0e);
    // 960K-1M
    assign hit_out[`MCD_BLK_UBIOS] = (addr_in[23:16] == 8'h0f);
endmodule

// *** rtl/mcd_range_cmp.sv ***
`timescale 1ns/10ps
// ==========================================================
// Inclusive range compare, empty when hi is below lo
module mcd_range_cmp #(
    parameter int WIDTH = 8
) (
    // Operands
    input  wire logic [WIDTH-1:0] lo_in,
    input  wire logic [WIDTH-1:0] hi_in,
    input  wire logic [WIDTH-1:0] x_in,
    // Result
    output logic                  hit_out
);
    if (WIDTH < 1) begin : g_chk
        $error("mcd_range_cmp: WIDTH must be at least 1");
    end

    assign hit_out = (x_in >= lo_in) && (x_in <= hi_in);
endmodule

// *** tb/mcd_master_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// PCI and ISA/DMA masters, one address phase per go pulse
module mcd_master_model
    import mcd_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         reset_n_in,
    // Commands from the bench
    input  wire logic         pci_go_in,
    input  wire logic         isa_go_in,
    input  wire logic         write_in,
    input  wire logic [31:0]  addr_in,
    // Requests towards the decoder
    output mcd_pci_req_t      pci_req_out,
    output mcd_isa_req_t      isa_req_out
);
    // Idle lines flip every cycle so a stale address never decodes
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pci_req_out <= '0;
            isa_req_out <= '0;
        end else begin
            pci_req_out.valid <= pci_go_in;
            pci_req_out.write <= pci_go_in ? write_in : ~pci_req_out.write;
            pci_req_out.addr  <= pci_go_in ? addr_in : ~pci_req_out.addr;
            isa_req_out.valid <= isa_go_in;
            isa_req_out.addr  <= isa_go_in ? addr_in[23:0] : ~isa_req_out.addr;
        end
    end
endmodule

// *** tb/memory_chip_select_decoder_bench.sv ***
`timescale 1ns/10ps
module memory_chip_select_decoder_bench
    import mcd_pkg::*;
;
    logic         core_clk_in;
    logic         reset_n_in;
    mcd_reg_req_t reg_req;
    logic [7:0]   rdata;
    mcd_pci_req_t pci_req;
    mcd_isa_req_t isa_req;
    logic         cs_n;
    logic         cs_valid;
    logic         fwd;
    logic         fwd_valid;
    logic         pci_go;
    logic         isa_go;
    logic         wr_bit;
    logic [31:0]  addr;
    int           bad_count;
    int           n_compared;

    // ==========================================================
    // Design and masters
    mcd_decoder u_dut (
        .core_clk_in                   (core_clk_in),
        .reset_n_in                    (reset_n_in),
        .reg_req_in                    (reg_req),
        .reg_rdata_out                 (rdata),
        .pci_req_in                    (pci_req),
        .main_memory_chip_select_n_out (cs_n),
        .chip_select_valid_out         (cs_valid),
        .isa_req_in                    (isa_req),
        .isa_forward_out               (fwd),
        .isa_forward_valid_out         (fwd_valid)
    );

    mcd_master_model u_masters (
        .core_clk_in (core_clk_in),
        .reset_n_in  (reset_n_in),
        .pci_go_in   (pci_go),
        .isa_go_in   (isa_go),
        .write_in    (wr_bit),
        .addr_in     (addr),
        .pci_req_out (pci_req),
        .isa_req_out (isa_req)
    );

    // ==========================================================
    // Clock, reset, watchdog
    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end

    initial begin
        // Whole run is a few hundred cycles; this leaves wide margin
        #100000;
        bad_count++;
        tally_and_finish();
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_in);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_in);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_in);
        reg_req.rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), rdata, e);
    endtask

    // Answer stands in the cycle after the taking edge, then drops
    task automatic pci_acc(input logic [31:0] a, input logic w, input logic hit);
        @(posedge core_clk_in);
        pci_go <= 1'b1;
        addr   <= a;
        wr_bit <= w;
        @(posedge core_clk_in);
        pci_go <= 1'b0;
        @(posedge core_clk_in);
        #1;
        check("cs valid", 8'(cs_valid), 8'h01);
        check($sformatf("cs_n %h", a), 8'(cs_n), 8'(!hit));
        @(posedge core_clk_in);
        #1;
        check("cs idle", 8'({cs_valid, cs_n}), 8'h01);
    endtask

    task automatic isa_acc(input logic [23:0] a, input logic hit);
        @(posedge core_clk_in);
        isa_go <= 1'b1;
        addr   <= {8'h00, a};
        @(posedge core_clk_in);
        isa_go <= 1'b0;
        @(posedge core_clk_in);
        #1;
        check("fwd valid", 8'(fwd_valid), 8'h01);
        check($sformatf("fwd %h", a), 8'(fwd), 8'(hit));
        @(posedge core_clk_in);
        #1;
        check("fwd idle", 8'({fwd_valid, fwd}), 8'h00);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd_reg(8'h44, 8'h00);
        rd_reg(8'h45, 8'h10);
        rd_reg(8'h46, 8'h0f);
        rd_reg(8'h47, 8'h00);
        rd_reg(8'h48, 8'h01);
        rd_reg(8'h50, 8'h00);
        rd_reg(8'h4f, 8'h00);
        wr_reg(8'h45, 8'ha5);
        rd_reg(8'h45, 8'ha5);
        wr_reg(8'h44, 8'hff);
        rd_reg(8'h44, 8'h1f);
        wr_reg(8'h50, 8'h55);
        rd_reg(8'h50, 8'h00);
        wr_reg(8'h45, 8'h10);
        wr_reg(8'h44, 8'h10);
        $display("test regs done");
    endtask

    task automatic t_top_mem();
        logic [7:0]  tv [4] = '{8'h00, 8'h01, 8'h7f, 8'hff};
        logic [31:0] top;
        for (int i = 0; i < 4; i++) begin
            top = (32'(tv[i]) + 32'h1) << 21;
            wr_reg(8'h47, tv[i]);
            pci_acc(32'h0020_0000, i[0], tv[i] != 8'h00);
            pci_acc(top - 32'h1, ~i[0], tv[i] != 8'h00);
            pci_acc(top, i[0], 1'b0);
        end
        pci_acc(32'h0010_0000, 1'b0, 1'b0);
        $display("test top of memory done");
    endtask

    // Hole limits kept at or above 1 Mbyte, as software must
    task automatic t_hole();
        wr_reg(8'h47, 8'h0f);
        wr_reg(8'h45, 8'h21);
        wr_reg(8'h46, 8'h2f);
        rd_reg(8'h4f, 8'h04);
        wr_reg(8'h4f, 8'h00);
        rd_reg(8'h4f, 8'h04);
        pci_acc(32'h0020_ffff, 1'b0, 1'b1);
        pci_acc(32'h0021_0000, 1'b1, 1'b0);
        pci_acc(32'h002f_ffff, 1'b0, 1'b0);
        pci_acc(32'h0030_0000, 1'b0, 1'b1);
        pci_acc(32'h0121_0000, 1'b0, 1'b1);
        wr_reg(8'h46, 8'h21);
        pci_acc(32'h0021_ffff, 1'b0, 1'b0);
        pci_acc(32'h0022_0000, 1'b0, 1'b1);
        wr_reg(8'h46, 8'h20);
        pci_acc(32'h0021_0000, 1'b0, 1'b1);
        $display("test hole done");
    endtask

    task automatic t_master();
        wr_reg(8'h44, 8'h00);
        pci_acc(32'h0020_0000, 1'b0, 1'b0);
        pci_acc(32'h0000_0000, 1'b1, 1'b0);
        wr_reg(8'h44, 8'h10);
        pci_acc(32'h0000_0000, 1'b1, 1'b1);
        // Low segments follow their own read and write enables
        wr_reg(8'h44, 8'h15);
        pci_acc(32'h0008_0000, 1'b0, 1'b1);
        pci_acc(32'h0009_ffff, 1'b1, 1'b0);
        wr_reg(8'h44, 8'h18);
        pci_acc(32'h000f_0000, 1'b1, 1'b1);
        pci_acc(32'h000f_ffff, 1'b0, 1'b0);
        wr_reg(8'h44, 8'h10);
        $display("test master enable done");
    endtask

    task automatic t_fwd();
        logic [23:0] blk [4] = '{24'h00_0000, 24'h08_0000, 24'h0a_0000, 24'h0e_0000};
        logic [23:0] top;
        wr_reg(8'h45, 8'h10);
        wr_reg(8'h46, 8'h0f);
        for (int c = 0; c < 16; c++) begin
            top = (24'(c) + 24'h1) << 20;
            wr_reg(8'h48, {4'(c), 4'h0});
            isa_acc(top - 24'h1, c != 0);
            if (c < 15)
                isa_acc(top, 1'b0);
        end
        wr_reg(8'h45, 8'h30);
        wr_reg(8'h46, 8'h30);
        isa_acc(24'h30_0000, 1'b0);
        isa_acc(24'h31_0000, 1'b1);
        wr_reg(8'h45, 8'h10);
        wr_reg(8'h46, 8'h0f);
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'h48, 8'h01 << k);
            for (int j = 0; j < 4; j++)
                isa_acc(blk[j], j == k);
        end
        isa_acc(24'h0c_0000, 1'b0);
        $display("test forwarding done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        reset_n_in = 1'b0;
        reg_req    = '0;
        pci_go     = 1'b0;
        isa_go     = 1'b0;
        wr_bit     = 1'b0;
        addr       = 32'h0000_0000;
        bad_count  = 0;
        n_compared = 0;
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        t_regs();
        t_top_mem();
        t_hole();
        t_master();
        t_fwd();
        tally_and_finish();
    end
endmodule
